// File: dcsc_pkg.sv
// constants and types for the divider channel sync controller
// Overview of operation
// - with slip accept set, a channel acts on broadcast slips; post-align repeats need repeat-shift only
// - with align accept set, a free-running channel rephases on broadcast or pin sync events
// - toggling align accept changes sensitivity only, never the divider state
// - start-up 00 runs free, rephased only by accepted align events
// - start-up 11 powers up before a pulse chain, rephases at start, powers down after
// - pulse mode buffer follows channel enable, or divider power when dynamic drive set
// - idle buffer outside chain drives low if idle-low set, else stays undriven
// - repeat-shift uses its count and restarts slips after every rephase: align start for align-accept free channels, pulse start for start-up 11
// - with repeat-shift, each slip event repeats the programmed 12-bit count
// - a done indication asserts once all pending phase operations are finished
// - shared timer counts periods set by a 12-bit count
// - timer sequences enable, reset, start and disable of dividers on requests
// - pulse duration is counted in timer periods, not output periods
// - pulse stream starts a fixed number of cycles after entering start phase
// - stopping the stream forces outputs low combinationally from the sequencer
// - channel enable clear disables; set, activity depends on mode and sleep
// - five-bit coarse delay shifts output in half cycles, up to 15.5 cycles over a 2-cycle base
// - enabled channel with force-low set and idle-low clear drives low at once, except a start-up 11 channel outside its chain, which stays undriven
package dcsc_pkg;
  localparam int NUM_CH = 14;
  localparam int DLY_LEN = 17;
  localparam int COARSE_BASE_CYC = 2;
  localparam logic [2:0] START_LAT_CYC = 3'h4;
  localparam logic [1:0] START_FREE = 2'h0;
  localparam logic [1:0] START_PULSE = 2'h3;
  localparam logic [1:0] GPI_SLIP = 2'h1;
  localparam logic [1:0] GPI_ALIGN = 2'h2;
  localparam logic [1:0] GPI_PULSE = 2'h3;
  localparam logic [11:0] CNT_RST = 12'h000;
  localparam logic [11:0] SLIP_ONE = 12'h001;
  localparam logic [3:0] PULSE_RST = 4'h0;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ENABLE = 3'b001,
    SEQ_RESET = 3'b010,
    SEQ_START = 3'b011,
    SEQ_RUN = 3'b100,
    SEQ_STOP = 3'b101
  } dcsc_seq_t;

  typedef struct packed {
    logic enable;
    logic slip_en;
    logic align_en;
    logic [1:0] startup;
    logic dyn_drv;
    logic force_low;
    logic idle_low;
    logic rpt_en;
    logic [11:0] rpt_cnt;
    logic [11:0] divider;
    logic [4:0] coarse;
  } dcsc_ch_cfg_t;

  typedef struct packed {
    logic slip;
    logic align;
    logic pulse;
  } dcsc_evt_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic [11:0] slip_left;
    logic [DLY_LEN-1:0] dly;
  } dcsc_ch_st_t;

  typedef struct packed {
    dcsc_seq_t seq;
    logic pulse_seq;
    logic [2:0] lat;
    logic [3:0] pulse_left;
    logic done;
    logic gpi_d;
    logic ext_d;
    dcsc_ch_st_t [NUM_CH-1:0] ch;
  } dcsc_top_st_t;

  typedef struct packed {
    logic [11:0] cnt;
  } dcsc_tmr_st_t;
endpackage

// File: dcsc_sync2.sv
// two flip-flop synchroniser with asynchronous clear
`timescale 1ns/1ps
module dcsc_sync2 #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic clr_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or negedge clr_n)
  begin
    if (!clr_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// File: dcsc_ref_timer.sv
// shared reference-period timer
`timescale 1ns/1ps
module dcsc_ref_timer
  import dcsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_sync_n,
  input wire logic run,
  input wire logic [11:0] period_count,
  output logic tick
);
  dcsc_tmr_st_t st_r;
  dcsc_tmr_st_t st_nxt;

  assign tick = run && (st_r.cnt <= SLIP_ONE);

  always_comb
  begin
    st_nxt = st_r;
    if (!run || tick)
      st_nxt.cnt = period_count;
    else
      st_nxt.cnt = st_r.cnt - SLIP_ONE;
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      st_r <= '{cnt: CNT_RST};
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  a_tick_single: assert property (tick && period_count > 12'h001 |=> !tick)
    else $error("timer tick lasted more than one cycle");
  a_tick_spacing: assert property (run && tick && period_count == 12'h003 ##1 run[*2]
    |-> ##1 (tick || !run))
    else $error("timer period length wrong");
endmodule

// File: dcsc_top.sv
// divider channels with sync, slip and pulse-generator sequencing
`timescale 1ns/1ps
module dcsc_top
  import dcsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic general_input_pin,
  input wire logic external_align_trigger,
  input wire logic [1:0] gpi_mode,
  input wire dcsc_evt_t sw_evt,
  input wire logic [11:0] reference_period_count,
  input wire logic [3:0] pulse_periods,
  input wire dcsc_ch_cfg_t [NUM_CH-1:0] ch_cfg,
  output logic [NUM_CH-1:0] converter_clock_output,
  output logic [NUM_CH-1:0] buffer_enable,
  output logic [NUM_CH-1:0] output_drive_en,
  output logic phase_ops_done,
  output logic seq_busy
);
  logic rst_sync_n;
  logic [1:0] pin_sync;
  logic tick;
  logic gpi_rise;
  logic ext_rise;
  logic slip_evt;
  logic align_req;
  logic pulse_req;
  logic start_fire;
  logic chain_on;
  logic seq_power;
  logic any_pending;
  logic [NUM_CH-1:0] powered;
  logic [NUM_CH-1:0] rephase;
  logic [NUM_CH-1:0] pulse_ch;
  logic [NUM_CH-1:0] div_bit;
  logic [NUM_CH-1:0] tap;
  logic [NUM_CH-1:0] half_r;
  logic [NUM_CH-1:0] force_low;
  logic [NUM_CH-1:0] idle_out;
  dcsc_top_st_t st_r;
  dcsc_top_st_t st_nxt;

  dcsc_sync2 #(.W(1)) u_rst_sync (
    .clock(clock),
    .clr_n(rst_n),
    .d(1'b1),
    .q(rst_sync_n)
  );

  dcsc_sync2 #(.W(2)) u_pin_sync (
    .clock(clock),
    .clr_n(rst_sync_n),
    .d({external_align_trigger, general_input_pin}),
    .q(pin_sync)
  );

  dcsc_ref_timer u_timer (
    .clock(clock),
    .rst_sync_n(rst_sync_n),
    .run(seq_busy),
    .period_count(reference_period_count),
    .tick(tick)
  );

  assign gpi_rise = pin_sync[0] && !st_r.gpi_d;
  assign ext_rise = pin_sync[1] && !st_r.ext_d;
  assign slip_evt = sw_evt.slip || (gpi_rise && gpi_mode == GPI_SLIP);
  assign align_req = sw_evt.align || ext_rise || (gpi_rise && gpi_mode == GPI_ALIGN);
  assign pulse_req = sw_evt.pulse || (gpi_rise && gpi_mode == GPI_PULSE);
  assign seq_busy = st_r.seq != SEQ_IDLE;
  assign start_fire = (st_r.seq == SEQ_START) && (st_r.lat == START_LAT_CYC - 3'h1);
  assign chain_on = (st_r.seq == SEQ_RUN) && st_r.pulse_seq;
  assign seq_power = st_r.pulse_seq && seq_busy;
  assign phase_ops_done = st_r.done;

  always_comb
  begin
    any_pending = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      pulse_ch[i] = ch_cfg[i].startup == START_PULSE;
      powered[i] = ch_cfg[i].enable && (!pulse_ch[i] || seq_power);
      rephase[i] = start_fire && (pulse_ch[i] ? st_r.pulse_seq
        : (ch_cfg[i].align_en && !st_r.pulse_seq));
      div_bit[i] = st_r.ch[i].cnt < {1'b0, ch_cfg[i].divider[11:1]};
      tap[i] = st_r.ch[i].dly[COARSE_BASE_CYC - 1 + int'(ch_cfg[i].coarse[4:1])];
      force_low[i] = ch_cfg[i].enable && ch_cfg[i].force_low && !ch_cfg[i].idle_low;
      idle_out[i] = pulse_ch[i] && !chain_on;
      buffer_enable[i] = ch_cfg[i].enable
        && ((pulse_ch[i] && ch_cfg[i].dyn_drv) ? powered[i] : 1'b1);
      output_drive_en[i] = buffer_enable[i] && !(idle_out[i] && !ch_cfg[i].idle_low);
      converter_clock_output[i] = (ch_cfg[i].coarse[0] ? half_r[i] : tap[i])
        && buffer_enable[i] && !force_low[i] && !idle_out[i];
      any_pending = any_pending || (st_r.ch[i].slip_left != CNT_RST);
    end
  end

  // half-cycle launch on the falling edge for odd coarse codes
  always_ff @(negedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      half_r <= '0;
    else
      half_r <= tap;
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.gpi_d = pin_sync[0];
    st_nxt.ext_d = pin_sync[1];
    case (st_r.seq)
      SEQ_IDLE:
      begin
        if (pulse_req || align_req)
        begin
          st_nxt.seq = SEQ_ENABLE;
          st_nxt.pulse_seq = pulse_req;
        end
      end
      SEQ_ENABLE:
      begin
        if (tick)
          st_nxt.seq = SEQ_RESET;
      end
      SEQ_RESET:
      begin
        if (tick)
        begin
          st_nxt.seq = SEQ_START;
          st_nxt.lat = 3'h0;
        end
      end
      SEQ_START:
      begin
        st_nxt.lat = st_r.lat + 3'h1;
        if (start_fire)
        begin
          st_nxt.seq = st_r.pulse_seq ? SEQ_RUN : SEQ_IDLE;
          st_nxt.pulse_left = pulse_periods;
        end
      end
      SEQ_RUN:
      begin
        if (tick)
        begin
          st_nxt.pulse_left = st_r.pulse_left - 4'h1;
          if (st_r.pulse_left <= 4'h1)
            st_nxt.seq = SEQ_STOP;
        end
      end
      SEQ_STOP:
      begin
        if (tick)
        begin
          st_nxt.seq = SEQ_IDLE;
          st_nxt.pulse_seq = 1'b0;
        end
      end
      default:
      begin
        st_nxt.seq = SEQ_IDLE;
      end
    endcase
    for (int i = 0; i < NUM_CH; i++)
    begin
      st_nxt.ch[i].dly = {st_r.ch[i].dly[DLY_LEN-2:0], div_bit[i]};
      if (!powered[i])
      begin
        st_nxt.ch[i].cnt = CNT_RST;
        st_nxt.ch[i].slip_left = CNT_RST;
      end
      else if (rephase[i])
      begin
        st_nxt.ch[i].cnt = CNT_RST;
        st_nxt.ch[i].slip_left = ch_cfg[i].rpt_en ? ch_cfg[i].rpt_cnt : CNT_RST;
      end
      else
      begin
        if (st_r.ch[i].slip_left != CNT_RST)
          st_nxt.ch[i].slip_left = st_r.ch[i].slip_left - SLIP_ONE;
        else if (ch_cfg[i].divider < 12'h002 || st_r.ch[i].cnt >= ch_cfg[i].divider - 12'h001)
          st_nxt.ch[i].cnt = CNT_RST;
        else
          st_nxt.ch[i].cnt = st_r.ch[i].cnt + 12'h001;
        if (slip_evt && ch_cfg[i].slip_en)
          st_nxt.ch[i].slip_left = ch_cfg[i].rpt_en ? ch_cfg[i].rpt_cnt : SLIP_ONE;
      end
    end
    st_nxt.done = !seq_busy && !any_pending && !slip_evt && !align_req && !pulse_req;
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  a_slip_hold_cnt: assert property (powered[0] && !rephase[0] && st_r.ch[0].slip_left != 12'h000
    |=> $stable(st_r.ch[0].cnt))
    else $error("divider advanced during a slip");
  a_slip_repeat: assert property (slip_evt && ch_cfg[0].slip_en && ch_cfg[0].rpt_en
    && powered[0] && !rephase[0] ##1 $stable(ch_cfg) |-> st_r.ch[0].slip_left == ch_cfg[0].rpt_cnt)
    else $error("repeat count not loaded on slip");
  a_slip_single: assert property (slip_evt && ch_cfg[0].slip_en && !ch_cfg[0].rpt_en
    && powered[0] && !rephase[0] |=> st_r.ch[0].slip_left == 12'h001)
    else $error("single slip not loaded");
  a_rephase_zero: assert property (rephase[0] && powered[0] |=> st_r.ch[0].cnt == 12'h000)
    else $error("divider not rephased");
  a_rephase_rpt: assert property (rephase[0] && powered[0] && ch_cfg[0].rpt_en ##1 $stable(ch_cfg)
    |-> st_r.ch[0].slip_left == ch_cfg[0].rpt_cnt)
    else $error("repeat slip not started after rephase");
  a_start_delay: assert property ($rose(st_r.seq == SEQ_START) |-> !start_fire[*3] ##1 start_fire)
    else $error("pulse start latency wrong");
  a_stop_gate: assert property (pulse_ch[0] && !chain_on |-> !converter_clock_output[0])
    else $error("pulse channel output active outside chain");
  a_drv_follow: assert property (pulse_ch[0] && ch_cfg[0].dyn_drv && ch_cfg[0].enable
    |-> buffer_enable[0] == seq_power)
    else $error("buffer enable does not track divider power");
  a_force_low: assert property (force_low[0] |-> !converter_clock_output[0])
    else $error("forced low output not low");
  a_idle_float: assert property (idle_out[0] && !ch_cfg[0].idle_low |-> !output_drive_en[0])
    else $error("idle output driven while floating selected");
  a_done_clear: assert property (any_pending |=> !phase_ops_done)
    else $error("done shown with slips pending");
  a_pulse_off: assert property (pulse_ch[0] && !seq_busy |=> st_r.ch[0].cnt == 12'h000)
    else $error("pulse channel divider running while idle");

  // sequencer steps
  a_busy_done: assert property (seq_busy |=> !phase_ops_done)
    else $error("done shown while sequencer busy");
  a_done_set: assert property (!seq_busy && !any_pending && !slip_evt && !align_req
    && !pulse_req |=> phase_ops_done)
    else $error("done missing with nothing pending");
  a_idle_enter: assert property (!seq_busy && (pulse_req || align_req)
    |=> st_r.seq == SEQ_ENABLE && st_r.pulse_seq == $past(pulse_req))
    else $error("request did not start the sequencer");
  a_idle_hold: assert property (!seq_busy && !pulse_req && !align_req |=> !seq_busy)
    else $error("sequencer left idle without request");
  a_enable_step: assert property (st_r.seq == SEQ_ENABLE && tick
    |=> st_r.seq == SEQ_RESET)
    else $error("enable phase did not end on tick");
  a_enable_wait: assert property (st_r.seq == SEQ_ENABLE && !tick
    |=> st_r.seq == SEQ_ENABLE)
    else $error("enable phase ended without tick");
  a_reset_step: assert property (st_r.seq == SEQ_RESET && tick
    |=> st_r.seq == SEQ_START && st_r.lat == 3'h0)
    else $error("reset phase did not enter start");
  a_align_end: assert property (start_fire && !st_r.pulse_seq |=> !seq_busy)
    else $error("align sequence did not return to idle");
  a_pulse_run: assert property (start_fire && st_r.pulse_seq
    |=> st_r.seq == SEQ_RUN && st_r.pulse_left == $past(pulse_periods))
    else $error("pulse chain not started with its length");
  a_run_count: assert property (st_r.seq == SEQ_RUN && tick && st_r.pulse_left > 4'h1
    |=> st_r.seq == SEQ_RUN && st_r.pulse_left == $past(st_r.pulse_left) - 4'h1)
    else $error("pulse chain not counted in timer periods");
  a_run_last: assert property (st_r.seq == SEQ_RUN && tick && st_r.pulse_left <= 4'h1
    |=> st_r.seq == SEQ_STOP)
    else $error("pulse chain did not stop");
  a_stop_end: assert property (st_r.seq == SEQ_STOP && tick
    |=> !seq_busy && !st_r.pulse_seq)
    else $error("stop phase did not power down");

  // channel behaviour
  a_free_count: assert property (powered[0] && !rephase[0] && st_r.ch[0].slip_left == 12'h000
    && ch_cfg[0].divider > 12'h001 && st_r.ch[0].cnt < ch_cfg[0].divider - 12'h001
    |=> st_r.ch[0].cnt == $past(st_r.ch[0].cnt) + 12'h001)
    else $error("free divider did not advance");
  a_free_wrap: assert property (powered[0] && !rephase[0] && st_r.ch[0].slip_left == 12'h000
    && ch_cfg[0].divider > 12'h001 && st_r.ch[0].cnt >= ch_cfg[0].divider - 12'h001
    |=> st_r.ch[0].cnt == 12'h000)
    else $error("free divider did not wrap");
  a_slip_down: assert property (powered[0] && !rephase[0] && st_r.ch[0].slip_left != 12'h000
    && !(slip_evt && ch_cfg[0].slip_en)
    |=> st_r.ch[0].slip_left == $past(st_r.ch[0].slip_left) - 12'h001)
    else $error("repeated slips not taken one at a time");
  a_unpowered_zero: assert property (!powered[0]
    |=> st_r.ch[0].cnt == 12'h000 && st_r.ch[0].slip_left == 12'h000)
    else $error("unpowered divider kept state");
  a_dyn_idle: assert property (pulse_ch[1] && ch_cfg[1].dyn_drv && !seq_busy
    |-> !buffer_enable[1])
    else $error("dynamic buffer on outside pulse chain");
  a_static_buf: assert property (pulse_ch[3] && !ch_cfg[3].dyn_drv
    |-> buffer_enable[3] == ch_cfg[3].enable)
    else $error("static buffer does not follow channel enable");
  a_run_drive: assert property (chain_on && pulse_ch[3] && ch_cfg[3].enable
    |-> output_drive_en[3])
    else $error("pulse output not driven during chain");
  a_gpi_edge: assert property (gpi_rise |=> !gpi_rise)
    else $error("input edge seen twice");

  c_align_seq: cover property (align_req && !seq_busy ##[1:300] start_fire);
  c_pulse_chain: cover property (chain_on ##[1:300] st_r.seq == SEQ_STOP);
  c_multislip: cover property (slip_evt && ch_cfg[0].rpt_en ##[1:300] phase_ops_done);
  c_pulse_power: cover property (seq_power && buffer_enable[1]);
  c_pin_event: cover property (gpi_rise ##1 !phase_ops_done);
endmodule

// File: dcsc_rx_model.sv
// receiving-side model that times the rising edges of every clock output
`timescale 1ns/1ps
module dcsc_rx_model
  import dcsc_pkg::*;
(
  input wire logic clock,
  input wire logic clr,
  input wire logic [NUM_CH-1:0] clk_in,
  output logic [NUM_CH-1:0][11:0] max_per,
  output logic [NUM_CH-1:0][15:0] rises
);
  logic [NUM_CH-1:0] prev;
  logic [NUM_CH-1:0] seen;
  logic [NUM_CH-1:0][11:0] since;
  // a receiver only listens: longest period and edge count per channel
  always @(posedge clock)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (clr)
      begin
        seen[i] = 1'b0;
        since[i] = 12'h000;
        max_per[i] = 12'h000;
        rises[i] = 16'h0000;
      end
      else if (clk_in[i] && !prev[i])
      begin
        if (seen[i] && since[i] > max_per[i])
          max_per[i] = since[i];
        seen[i] = 1'b1;
        since[i] = 12'h001;
        rises[i] = rises[i] + 16'h0001;
      end
      else
        since[i] = since[i] + 12'h001;
      prev[i] = clk_in[i];
    end
  end
endmodule

// File: tb.sv
// self-checking testbench for the divider channel sync controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import dcsc_pkg::*;
  logic clock;
  logic rst_n;
  logic general_input_pin;
  logic external_align_trigger;
  logic clr;
  logic on;
  logic [1:0] gpi_mode;
  dcsc_evt_t sw_evt;
  logic [11:0] reference_period_count;
  logic [3:0] pulse_periods;
  dcsc_ch_cfg_t [NUM_CH-1:0] cfg;
  logic [NUM_CH-1:0] converter_clock_output;
  logic [NUM_CH-1:0] buffer_enable;
  logic [NUM_CH-1:0] output_drive_en;
  logic phase_ops_done;
  logic seq_busy;
  logic [NUM_CH-1:0][11:0] max_per;
  logic [NUM_CH-1:0][15:0] rises;
  logic [31:0] seed = 32'h0000003F;
  int n_fail, comparisons, cycles, n, m, r, p, e;

  dcsc_top i_dut (.clock(clock), .rst_n(rst_n), .general_input_pin(general_input_pin),
    .external_align_trigger(external_align_trigger), .gpi_mode(gpi_mode), .sw_evt(sw_evt),
    .reference_period_count(reference_period_count), .pulse_periods(pulse_periods),
    .ch_cfg(cfg), .converter_clock_output(converter_clock_output),
    .buffer_enable(buffer_enable), .output_drive_en(output_drive_en),
    .phase_ops_done(phase_ops_done), .seq_busy(seq_busy));
  dcsc_rx_model i_rx (.clock(clock), .clr(clr), .clk_in(converter_clock_output),
    .max_per(max_per), .rises(rises));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int near(input int ex, input int g);
    return (g >= ex - 2 && g <= ex + 2) ? ex : g;
  endfunction

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic fire(input dcsc_evt_t ev);
    sw_evt = ev;
    step(1);
    sw_evt = '0;
  endtask

  task automatic restart_rx();
    clr = 1'b1;
    step(1);
    clr = 1'b0;
  endtask

  task automatic settle(output int nb, output int nd);
    nb = 0;
    nd = 0;
    on = 1'b0;
    while (seq_busy === 1'b1 && nb < 2000)
    begin
      on |= buffer_enable[1];
      step(1);
      nb++;
    end
    while (phase_ops_done !== 1'b1 && nd < 500)
    begin
      step(1);
      nd++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    clr = 1'b1;
    general_input_pin = 1'b0;
    external_align_trigger = 1'b0;
    gpi_mode = GPI_SLIP;
    sw_evt = '0;
    reference_period_count = 12'h028;
    pulse_periods = 4'h2;
    cfg = '0;
    // pulse channels divide by 40 with no coarse offset
    cfg[0] = '{1'b1, 1'b1, 1'b0, START_FREE, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 12'h008, 5'h00};
    cfg[1] = '{1'b1, 1'b0, 1'b1, START_PULSE, 1'b1, 1'b0, 1'b1, 1'b0, 12'h000, 12'h028, 5'h00};
    cfg[2] = '{1'b1, 1'b0, 1'b0, START_FREE, 1'b0, 1'b1, 1'b0, 1'b0, 12'h000, 12'h004, 5'h00};
    cfg[3] = '{1'b1, 1'b0, 1'b1, START_PULSE, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 12'h028, 5'h00};
    cfg[4] = '{1'b1, 1'b0, 1'b1, START_PULSE, 1'b0, 1'b0, 1'b1, 1'b0, 12'h000, 12'h028, 5'h00};
    cfg[5] = '{1'b0, 1'b0, 1'b0, START_FREE, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 12'h004, 5'h00};
    step(12);
    rst_n = 1'b1;
    step(6);
    `CHK("done after reset", 1'b1, phase_ops_done)
    `CHK("busy after reset", 1'b0, seq_busy)
    restart_rx();
    step(40);
    cfg[0].align_en = 1'b1;
    step(20);
    cfg[0].align_en = 1'b0;
    step(20);
    `CHK("free period", 12'h008, max_per[0])
    `CHK("forced low edges", 16'h0000, rises[2])
    `CHK("disabled edges", 16'h0000, rises[5])
    `CHK("disabled buffer", 1'b0, buffer_enable[5])
    `CHK("dynamic idle buffer", 1'b0, buffer_enable[1])
    `CHK("static buffer", 1'b1, buffer_enable[3])
    `CHK("idle float", 1'b0, output_drive_en[3])
    `CHK("idle drive", 1'b1, output_drive_en[4])
    `CHK("idle level", 1'b0, converter_clock_output[4])
    $display("test static outputs finished");
    for (int k = 0; k < 6; k++)
    begin
      // repeat counts are never zero
      n = 4 + int'(rnd() & 32'h3F);
      cfg[0].slip_en = (k != 5);
      cfg[0].rpt_en = (k > 0);
      cfg[0].rpt_cnt = n[11:0];
      if (k == 0)
        n = 1;
      if (k == 5)
        n = 0;
      restart_rx();
      step(20);
      fire(3'b100);
      m = 0;
      while (phase_ops_done === 1'b1 && m < 4)
      begin
        step(1);
        m++;
      end
      settle(e, m);
      step(24);
      `CHK("slip pending span", (n == 0) ? 0 : n + 1, near(n + 1, m + 1) - ((n == 0) ? 1 : 0))
      `CHK("slipped period", 12'h008 + n[11:0], max_per[0])
    end
    $display("test slips finished");
    cfg[0].align_en = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      // timer period a multiple of every divider and at most 4 MHz
      r = 40 * (1 + int'(rnd() & 32'h1));
      p = int'(rnd() & 32'h3);
      n = 4 + int'(rnd() & 32'hF);
      cfg[0].rpt_cnt = n[11:0];
      reference_period_count = r[11:0];
      pulse_periods = p[3:0];
      fire(k[0] ? 3'b001 : 3'b010);
      settle(m, e);
      n = k[0] ? 0 : n;
      e = e - 1;
      r = k[0] ? (3 + ((p == 0) ? 1 : p)) * r : 2 * r + int'(START_LAT_CYC);
      `CHK("sequence length", r, m)
      `CHK("pulse channel powered", k[0], on)
      `CHK("pulse buffer after", 1'b0, buffer_enable[1])
      `CHK("pulse output after", 1'b0, converter_clock_output[1])
      `CHK("repeat after start", n, e)
      step(10);
    end
    $display("test sequences finished");
    for (int k = 1; k < 5; k++)
    begin
      gpi_mode = k[1:0];
      if (k < 4)
        general_input_pin = 1'b1;
      else
        external_align_trigger = 1'b1;
      m = 0;
      while (seq_busy === 1'b0 && phase_ops_done === 1'b1 && m < 10)
      begin
        step(1);
        m++;
      end
      `CHK("pin reaction", 1'b1, m < 10)
      general_input_pin = 1'b0;
      external_align_trigger = 1'b0;
      settle(m, e);
      step(10);
    end
    $display("test pins finished");
    report_and_stop();
  end
endmodule
